/* skam_pkg.sv */
// Shared constants and carrier types for the scanned key associative memory.
// Assumes a single synchronous clock domain; no bus registers.
package skam_pkg;
	localparam int ELEM_WORDS      = 8;
	localparam int ROW_ADDR_W      = 3;
	localparam int WORD_ADDR_W     = 4;
	localparam int ROW_SEL_BIT     = 3;
	localparam int KEY_LEN_DEF     = 16;
	localparam int DATA_W_DEF      = 8;
	localparam int FIELD_MAX_DEF   = 4;

	typedef enum logic [1:0] {
		SKAM_IDLE   = 2'b00,
		SKAM_SCAN   = 2'b01,
		SKAM_RESULT = 2'b10
	} skam_state_e;

	typedef struct packed {
		logic [WORD_ADDR_W-1:0] addr;
		logic                   row_sel;
		logic                   any;
	} skam_sel_s;
endpackage

/* skam_encoder.sv */
// Match address encoder: eight word match flags to three word address lines and a row select line.
// Assumes at most one flag of the group is set at a time.
`timescale 1ns/1ps
module skam_encoder
	import skam_pkg::*;
(
	input  wire logic [ELEM_WORDS-1:0] word_match_flag,
	output skam_sel_s                  sel
);
	logic [WORD_ADDR_W-1:0] a;
	always_comb begin
		// Flag 0 is index 0 of the vector, so the lines give the binary of the 0-based flag index.
		a[0] = word_match_flag[1] | word_match_flag[3] | word_match_flag[5] | word_match_flag[7];
		a[1] = word_match_flag[2] | word_match_flag[3] | word_match_flag[6] | word_match_flag[7];
		a[2] = word_match_flag[4] | word_match_flag[5] | word_match_flag[6] | word_match_flag[7];
		a[ROW_SEL_BIT] = a[0] | a[1] | a[2] | word_match_flag[0];
		sel.addr    = a;
		sel.row_sel = a[ROW_SEL_BIT];
		sel.any     = |word_match_flag;
	end
endmodule

/* skam_top.sv */
// Associative memory: scanned key section, bit-serial compare, parallel data section.
// Assumes the host supplies the search key bit, the data register and the write strobe
// on clk_sys, and keeps matching keys unique.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Storage is built of eight-word elements, three low address lines picking a word and a fourth picking the row.
// - Key registers act as circulating registers by scanning bit addresses, never by shifting bits.
// - The scan counter selects the same bit position in every key register at once and steps in order.
// - The selected bit of every key register can be read and written while it is selected.
// - Key length is a multiple of eight with unused positions allowed, and the word count follows the elements fitted.
// - The search key is an external serial register whose selected bit goes to every comparator.
// - Comparison runs one bit per step in every word at once, each word with its own compare logic.
// - A word whose compared field fully agrees sets its own match flag.
// - A search steps the scan counter through a programmed range, choosing the compared field.
// - A search may cover several separate non-adjacent fields.
// - The set match flag picks the data word paired with that key register for access.
// - Each encoder maps eight match flags to three word lines and an OR-ed row select line.
// - With a word selected, the host's write strobe chooses write or read through its data register.
// - Data moves between the data register and the data section all bits in parallel.
module skam_top
	import skam_pkg::*;
#(
	parameter int KEY_ELEMS = 2,
	parameter int WORDS     = 16,
	parameter int DATA_W    = DATA_W_DEF,
	parameter int FIELDS    = FIELD_MAX_DEF
) (
	input  wire logic                          clk_sys,
	input  wire logic                          reset_n,
	input  wire logic                          search_start,
	input  wire logic [FIELDS-1:0]             field_enable,
	input  wire logic [FIELDS*$clog2(KEY_ELEMS*ELEM_WORDS)-1:0] field_first,
	input  wire logic [FIELDS*$clog2(KEY_ELEMS*ELEM_WORDS)-1:0] field_last,
	input  wire logic                          search_key_bit,
	input  wire logic                          key_write,
	input  wire logic [$clog2(KEY_ELEMS*ELEM_WORDS)-1:0] key_bit_addr,
	input  wire logic [WORDS-1:0]              key_bits_in,
	input  wire logic [WORDS-1:0]              key_bits_we,
	input  wire logic                          data_write_strobe,
	input  wire logic [DATA_W-1:0]             data_word_register,
	output logic      [$clog2(KEY_ELEMS*ELEM_WORDS)-1:0] scan_bit_pos,
	output logic                               scan_active,
	output logic      [WORDS-1:0]              key_bits_out,
	output logic      [WORDS-1:0]              word_match_flag,
	output logic                               search_done,
	output logic                               word_selected,
	output logic      [$clog2(WORDS)-1:0]      selected_word,
	output logic      [DATA_W-1:0]             data_read
);
	localparam int KEY_LEN = KEY_ELEMS * ELEM_WORDS;
	localparam int PW      = $clog2(KEY_LEN);
	localparam int FW      = (FIELDS > 1) ? $clog2(FIELDS) : 1;
	localparam int ROWS    = WORDS / ELEM_WORDS;
	localparam int WAW     = $clog2(WORDS);

	////////////////////////////////////////////////////////////////////////////
	// Key section: bit-position major, so one address reaches every word.
	logic [WORDS-1:0] key_mem [KEY_LEN];
	logic [WORDS-1:0] key_row;
	logic [PW-1:0]    key_addr;

	// During a search the scan counter owns the address; otherwise the host does.
	assign key_addr     = scan_active ? scan_bit_pos : key_bit_addr;
	assign key_row      = key_mem[key_addr];
	assign key_bits_out = key_row;

	always_ff @(posedge clk_sys) begin
		if (key_write) begin
			for (int w = 0; w < WORDS; w++) begin
				if (key_bits_we[w]) begin
					key_mem[key_addr][w] <= key_bits_in[w];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Scan sequencer.
	skam_state_e      state_reg, state_next;
	logic [PW-1:0]    pos_reg, pos_next;
	logic [FW-1:0]    fld_reg, fld_next;
	logic [WORDS-1:0] agree_reg, agree_next;
	logic [WORDS-1:0] match_reg, match_next;
	logic             done_reg, done_next;
	logic [PW-1:0]    f_first [FIELDS];
	logic [PW-1:0]    f_last  [FIELDS];
	logic [FW-1:0]    nxt_fld;
	logic             nxt_found;

	genvar gi;
	generate
		for (gi = 0; gi < FIELDS; gi++) begin : g_fld
			assign f_first[gi] = field_first[gi*PW +: PW];
			assign f_last[gi]  = field_last[gi*PW +: PW];
		end
	endgenerate

	// Finds the next enabled field after the current one; fields need not be adjacent.
	always_comb begin
		nxt_fld   = '0;
		nxt_found = 1'b0;
		for (int f = FIELDS - 1; f >= 0; f--) begin
			if (field_enable[f] && (FW'(f) > fld_reg)) begin
				nxt_fld   = FW'(f);
				nxt_found = 1'b1;
			end
		end
	end

	logic [FW-1:0] first_fld;
	logic          first_found;
	always_comb begin
		first_fld   = '0;
		first_found = 1'b0;
		for (int f = FIELDS - 1; f >= 0; f--) begin
			if (field_enable[f]) begin
				first_fld   = FW'(f);
				first_found = 1'b1;
			end
		end
	end

	// Each word keeps its own running agreement; the XNOR is its compare network.
	logic [WORDS-1:0] bit_agree;
	generate
		for (gi = 0; gi < WORDS; gi++) begin : g_cmp
			assign bit_agree[gi] = ~(key_row[gi] ^ search_key_bit);
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		pos_next   = pos_reg;
		fld_next   = fld_reg;
		agree_next = agree_reg;
		match_next = match_reg;
		done_next  = 1'b0;
		unique case (state_reg)
			SKAM_IDLE, SKAM_RESULT: begin
				if (search_start) begin
					match_next = '0;
					agree_next = '1;
					if (first_found) begin
						fld_next   = first_fld;
						pos_next   = f_first[first_fld];
						state_next = SKAM_SCAN;
					end else begin
						state_next = SKAM_IDLE;
					end
				end
			end
			SKAM_SCAN: begin
				agree_next = agree_reg & bit_agree;
				if (pos_reg != f_last[fld_reg]) begin
					pos_next = pos_reg + PW'(1);
				end else if (nxt_found) begin
					fld_next = nxt_fld;
					pos_next = f_first[nxt_fld];
				end else begin
					match_next = agree_reg & bit_agree;
					done_next  = 1'b1;
					state_next = SKAM_RESULT;
				end
			end
			default: begin
				state_next = SKAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg <= SKAM_IDLE;
			pos_reg   <= '0;
			fld_reg   <= '0;
			agree_reg <= '0;
			match_reg <= '0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			pos_reg   <= pos_next;
			fld_reg   <= fld_next;
			agree_reg <= agree_next;
			match_reg <= match_next;
			done_reg  <= done_next;
		end
	end

	assign scan_active     = (state_reg == SKAM_SCAN);
	assign scan_bit_pos    = pos_reg;
	assign word_match_flag = match_reg;
	assign search_done     = done_reg;

	////////////////////////////////////////////////////////////////////////////
	// Address encoders, one per row of eight words.
	skam_sel_s        row_sel [ROWS];
	logic [WAW-1:0]   sel_addr;
	logic             sel_any;

	generate
		for (gi = 0; gi < ROWS; gi++) begin : g_enc
			skam_encoder u_enc (
				.word_match_flag (match_reg[gi*ELEM_WORDS +: ELEM_WORDS]),
				.sel             (row_sel[gi])
			);
		end
	endgenerate

	// Only one row select line may be high when the host keeps keys unique.
	always_comb begin
		sel_addr = '0;
		sel_any  = 1'b0;
		for (int r = 0; r < ROWS; r++) begin
			if (row_sel[r].row_sel) begin
				sel_addr = WAW'(r * ELEM_WORDS) | WAW'(row_sel[r].addr[ROW_ADDR_W-1:0]);
				sel_any  = 1'b1;
			end
		end
	end

	assign word_selected = sel_any;
	assign selected_word = sel_addr;

	////////////////////////////////////////////////////////////////////////////
	// Data section, whole words at a time.
	logic [DATA_W-1:0] data_mem [WORDS];
	logic [DATA_W-1:0] rd_reg, rd_next;

	always_ff @(posedge clk_sys) begin
		if (sel_any && data_write_strobe) begin
			data_mem[sel_addr] <= data_word_register;
		end
	end

	always_comb begin
		rd_next = rd_reg;
		if (sel_any && !data_write_strobe) begin
			rd_next = data_mem[sel_addr];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_reg <= '0;
		end else begin
			rd_reg <= rd_next;
		end
	end

	assign data_read = rd_reg;
endmodule

/* skam_chk_sva.sv */
// Port checker for the associative memory top.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module skam_chk
	import skam_pkg::*;
#(
	parameter int KEY_ELEMS = 2,
	parameter int WORDS     = 16,
	parameter int DATA_W    = 8,
	parameter int FIELDS    = 4
) (
	input wire logic                                     clk_sys,
	input wire logic                                     reset_n,
	input wire logic                                     search_start,
	input wire logic                                     key_write,
	input wire logic [$clog2(KEY_ELEMS*ELEM_WORDS)-1:0] key_bit_addr,
	input wire logic [WORDS-1:0]                         key_bits_in,
	input wire logic [WORDS-1:0]                         key_bits_we,
	input wire logic                                     data_write_strobe,
	input wire logic [DATA_W-1:0]                        data_word_register,
	input wire logic [$clog2(KEY_ELEMS*ELEM_WORDS)-1:0] scan_bit_pos,
	input wire logic                                     scan_active,
	input wire logic [WORDS-1:0]                         key_bits_out,
	input wire logic [WORDS-1:0]                         word_match_flag,
	input wire logic                                     search_done,
	input wire logic                                     word_selected,
	input wire logic [$clog2(WORDS)-1:0]                 selected_word,
	input wire logic [DATA_W-1:0]                        data_read
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_wr; word_selected && data_write_strobe; endsequence
	sequence s_rd; word_selected && !data_write_strobe && $stable(selected_word); endsequence
	sequence s_kw; key_write && !scan_active && !search_start; endsequence
	////////////////////////////////////////////////////////////////////////////////
	start_clr_a: assert property (search_start && !scan_active |=> word_match_flag == '0)
		else $error("match flags not cleared at search start");
	scan_step_a: assert property (scan_active ##1 scan_active |-> scan_bit_pos != $past(scan_bit_pos))
		else $error("scan position did not move");
	done_end_a: assert property ($fell(scan_active) |-> search_done)
		else $error("scan ended without done");
	done_pulse_a: assert property (search_done |=> !search_done)
		else $error("done held longer than one cycle");
	sel_any_a: assert property (word_selected == (|word_match_flag))
		else $error("selection disagrees with match flags");
	enc_word_a: assert property ($onehot(word_match_flag) |-> word_match_flag[selected_word])
		else $error("encoded address misses the matching word");
	match_hold_a: assert property (!scan_active && !search_start |=> $stable(word_match_flag))
		else $error("match flags changed outside a search");
	data_back_a: assert property (s_wr ##1 s_rd |=> data_read == $past(data_word_register, 2))
		else $error("read data differs from written word");
	key_back_a: assert property (s_kw ##1 (!scan_active && $stable(key_bit_addr)) |->
		(key_bits_out & $past(key_bits_we)) == ($past(key_bits_in) & $past(key_bits_we)))
		else $error("key bit readback wrong");
endmodule
bind skam_top skam_chk #(.KEY_ELEMS(KEY_ELEMS), .WORDS(WORDS), .DATA_W(DATA_W), .FIELDS(FIELDS))
	i_skam_chk (.*);

/* skam_host.sv */
// Host-side search key register that presents its selected bit.
// Assumes the scan position comes straight from the memory block.
`timescale 1ns/1ps
module skam_host (
	input  wire logic [3:0]  scan_bit_pos,
	input  wire logic [15:0] search_key,
	output logic             search_key_bit
);
	// The bench only loads keys held by at most one stored word.
	assign search_key_bit = search_key[scan_bit_pos];
endmodule

/* testbench.sv */
// Directed bench for the associative memory top with a host key model.
// Assumes a 50 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
module testbench;
	logic        clk_sys, reset_n, search_start, key_write, data_write_strobe;
	logic        search_key_bit, scan_active, search_done, word_selected;
	logic [3:0]  field_enable, key_bit_addr, scan_bit_pos, selected_word;
	logic [15:0] field_first, field_last, key_bits_in, key_bits_we;
	logic [15:0] key_bits_out, word_match_flag, search_key;
	logic [7:0]  data_word_register, data_read;
	int          n_mismatch = 0;
	int          n_compared = 0;
	skam_top i_skam_top (.*);
	skam_host i_skam_host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Every nibble is a distinct function of the word, so any whole nibble is unique.
	function automatic logic [15:0] keyof(input logic [3:0] w);
		return {w, ~w, w ^ 4'h5, w + 4'h3};
	endfunction
	task tk;
		@(posedge clk_sys);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_keys;
		logic [15:0] k;
		for (int p = 0; p < 16; p++) begin
			for (int w = 0; w < 16; w++) begin
				k = keyof(4'(w));
				key_bits_in[w] = k[p];
			end
			key_bit_addr = 4'(p);
			key_bits_we = 16'hffff;
			key_write = 1'b1;
			tk;
			key_write = 1'b0;
			chk(key_bits_out, key_bits_in);
			tk;
		end
		$display("keys test finished");
	endtask
	task t_search(input logic [3:0] en, input logic [15:0] ff, fl, sk, input int n,
		input logic [15:0] exp);
		int c;
		logic [3:0] p0;
		p0 = 4'h0;
		for (int i = 3; i >= 0; i--) if (en[i]) p0 = ff[i*4+:4];
		field_enable = en;
		field_first = ff;
		field_last = fl;
		search_key = sk;
		search_start = 1'b1;
		tk;
		search_start = 1'b0;
		chk(16'(scan_bit_pos), 16'(p0));
		c = 0;
		while (search_done !== 1'b1 && c < 40) begin
			tk;
			c++;
		end
		if (c >= 40) begin
			n_mismatch++;
			close_out;
		end
		chk(16'(c), 16'(n));
		chk(word_match_flag, exp);
		chk(16'(word_selected), 16'(exp != 16'h0000));
		if (exp != 16'h0000) chk(16'(selected_word), 16'($clog2(exp)));
	endtask
	task t_hits;
		int ws[4] = '{0, 7, 8, 15};
		foreach (ws[i]) begin
			t_search(4'h1, 16'h000c, 16'h000f, keyof(4'(ws[i])), 4, 16'h1 << ws[i]);
		end
		t_search(4'h3, 16'h00c0, 16'h00f3, keyof(4'h5), 8, 16'h0020);
		t_search(4'hc, 16'h4800, 16'h4b00, keyof(4'h9), 5, 16'h0200);
		t_search(4'h3, 16'h00c0, 16'h00f3, keyof(4'h5) ^ 16'h0001, 8, 16'h0000);
		$display("search test finished");
	endtask
	task wr(input logic [7:0] v);
		data_word_register = v;
		data_write_strobe = 1'b1;
		tk;
		data_write_strobe = 1'b0;
		tk;
		chk(16'(data_read), 16'(v));
	endtask
	task t_data;
		t_search(4'h1, 16'h000c, 16'h000f, keyof(4'h3), 4, 16'h0008);
		wr(8'h5a);
		t_search(4'h1, 16'h000c, 16'h000f, keyof(4'hc), 4, 16'h1000);
		wr(8'ha5);
		t_search(4'h1, 16'h000c, 16'h000f, keyof(4'h3), 4, 16'h0008);
		tk;
		chk(16'(data_read), 16'h005a);
		$display("data test finished");
	endtask
	task t_refuse;
		field_enable = 4'h0;
		search_start = 1'b1;
		tk;
		search_start = 1'b0;
		repeat (10) begin
			tk;
			chk(16'({search_done, scan_active}), 16'h0000);
		end
		chk(word_match_flag, 16'h0000);
		$display("refusal test finished");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, search_start, key_write, data_write_strobe} = 4'h0;
		{field_enable, key_bit_addr} = 8'h00;
		{field_first, field_last, key_bits_in, key_bits_we, search_key} = '0;
		data_word_register = 8'h00;
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		t_keys;
		t_hits;
		t_data;
		t_refuse;
		close_out;
	end
endmodule
